// ---- hdl/ebl_params.svh ----
`ifndef EBL_PARAMS_SVH
`define EBL_PARAMS_SVH

// Register byte offsets
`define EBL_OFS_CTRL       8'h00
`define EBL_OFS_ENABLE     8'h04
`define EBL_OFS_STATUS     8'h08
`define EBL_OFS_RAM_CMP    8'h0c
`define EBL_OFS_RAM_COUNT  8'h10
`define EBL_OFS_TBL_ADDR   8'h14
`define EBL_OFS_TBL_DATA   8'h18
`define EBL_OFS_TBL_IADDR  8'h1c
`define EBL_OFS_BP_ADDR    8'h20
`define EBL_OFS_BP_DATA    8'h24
`define EBL_OFS_CODE_SIZE  8'h28
`define EBL_OFS_TRACE_PTR  8'h2c
`define EBL_OFS_CYCLES     8'h30

// Control register bits
`define EBL_CTRL_START     0
`define EBL_CTRL_USER      1
`define EBL_CTRL_EXPAND    2

// Cause and enable bit positions
`define EBL_C_RAM_ADDR     0
`define EBL_C_TBL_DATA     1
`define EBL_C_TBL_ADDR     2
`define EBL_C_BREAKPT      3
`define EBL_C_TRACE_FULL   4
`define EBL_C_CYC_OVF      5
`define EBL_C_PROBE        6
`define EBL_C_HALT         7
`define EBL_C_CALL_STK     8
`define EBL_C_REG_STK      9
`define EBL_C_NEXIST       10
`define EBL_C_USER         11
`define EBL_NUM_CAUSE      12
`define EBL_NUM_COND       10

// Reset values
`define EBL_RST_ENABLE     10'h000
`define EBL_RST_CODE_SIZE  17'h02000
`define EBL_RST_TEST_BASE  16'h0fe0
`define EBL_TEST_WORDS     32

// Counter sizes
`define EBL_TRACE_BITS     13
`define EBL_CYC_BITS       24

`endif

// ---- hdl/ebl_pkg.sv ----
package ebl_pkg;

	// Emulation run state
	typedef enum logic [1:0] {
		EBL_STOPPED,
		EBL_RUNNING,
		EBL_BREAKING
	} ebl_run_e;

	// Events reported by the evaluation core, one clock each
	typedef struct packed {
		logic        instr_done;   // Last clock of an instruction
		logic [15:0] instr_addr;   // Address of that instruction's first word
		logic [1:0]  instr_cycles; // Machine cycles it took
		logic        instr_halt;   // Instruction is HALT
		logic        fetch;        // Instruction word fetch
		logic [15:0] fetch_addr;   // Address of that fetch
		logic        tbl_rd;       // Table-read access (high or low)
		logic [15:0] tbl_addr;     // Code address read by the table read
		logic [15:0] tbl_data;     // Data returned by the table read
		logic        ram_wr;       // Instruction write to data memory
		logic [11:0] ram_addr;     // Data memory address written
		logic        call_push;    // Call stack push
		logic        call_pop;     // Call stack pop
		logic [4:0]  call_sp;      // Call stack pointer before the access
		logic        reg_push;     // Register stack push
		logic        reg_pop;      // Register stack pop
		logic [3:0]  reg_sp;       // Register stack pointer before the access
		logic        s2_start;     // Start of the second state cycle
		logic        s2_end;       // End of the second state cycle
		logic        trace_wr;     // One trace entry written
	} ebl_core_ev_s;

endpackage

// ---- hdl/ebl_break_logic.sv ----
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "ebl_params.svh"

// Summary of operation
// - RAM address match after programmed write count
// - RAM compare covers whole data space
// - Data compare mask: one compares, zero ignores
// - Address compare mask has same meaning
// - Table read data match raises request
// - Optional instruction address qualifies table data match
// - Table read address match with mask
// - Table matches fire on first access
// - Match breaks stop one instruction later
// - Table data or second words never fire
// - Per-address breakpoint bits raise requests
// - Trace pointer overflow raises trace full
// - 24-bit cycle counter overflow raises request
// - Counter reads 1..cycles after overflow
// - Resume clears pending overflow requests
// - Probe rising edge, sampled second state cycle
// - HALT raises power-down break request
// - Call stack over/underflow raises request
// - Register stack over/underflow raises request
// - Nonexistent code fetch forces immediate stop
// - Test data area always nonexistent
// - User break stops and exits halt
// - Accepted break request ends the run
module ebl_break_logic
	import ebl_pkg::*;
#(
	parameter int CALL_DEPTH = 16,   // Call stack entries
	parameter int REG_DEPTH  = 8,    // Register stack entries
	parameter int CODE_AW    = 16    // Code address width
)(
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// APB slave
	input  wire logic         psel_i,
	input  wire logic         penable_i,
	input  wire logic         pwrite_i,
	input  wire logic [7:0]   paddr_i,
	input  wire logic [31:0]  pwdata_i,
	output logic      [31:0]  prdata_o,
	output logic              pready_o,
	output logic              pslverr_o,
	// Evaluation core side
	input  wire ebl_core_ev_s core_ev_i,
	input  wire logic         break_ack_i,
	input  wire logic         probe_stop_input_i,
	output logic              run_o,
	output logic              break_req_o,
	output logic              force_stop_o,
	output logic              halt_exit_o
);

	// Parameter checks
	if (CALL_DEPTH < 1 || CALL_DEPTH > 31)
		$error("CALL_DEPTH must fit the 5-bit pointer");
	if (REG_DEPTH < 1 || REG_DEPTH > 15)
		$error("REG_DEPTH must fit the 4-bit pointer");
	if (CODE_AW != 16)
		$error("CODE_AW must be 16");

	localparam int NC = `EBL_NUM_CAUSE;
	localparam int NE = `EBL_NUM_COND;

	// Software state
	ebl_run_e             run_reg;          // Run state
	logic [NE-1:0]        enable_reg;       // Per-condition enables
	logic                 expand_reg;       // Full 64K code space
	logic [11:0]          ram_cmp_reg;      // RAM address compare value
	logic [11:0]          ram_mask_reg;     // RAM address mask
	logic [7:0]           ram_count_reg;    // Writes needed for a match
	logic [15:0]          tbl_addr_reg;     // Table address compare value
	logic [15:0]          tbl_amask_reg;    // Table address mask
	logic [15:0]          tbl_data_reg;     // Table data compare value
	logic [15:0]          tbl_dmask_reg;    // Table data mask
	logic [15:0]          tbl_iaddr_reg;    // Qualifying instruction address
	logic                 tbl_iq_reg;       // Qualifier in use
	logic [15:0]          bp_addr_reg;      // Breakpoint bit pointer
	logic [16:0]          code_size_reg;    // Physically present code words
	logic [2**CODE_AW-1:0] bp_mem;          // One breakpoint bit per code word

	// Condition state
	logic [NC-1:0]        cause_reg;        // Sticky satisfied conditions
	logic [7:0]           ram_hits_reg;     // Qualifying writes seen
	logic                 match_now_reg;    // Match seen in current instruction
	logic                 match_late_reg;   // Match waiting one instruction
	logic [2:0]           match_kind_reg;   // Which matches are in flight
	logic [2:0]           match_hold_reg;   // Kinds waiting one instruction
	logic [`EBL_TRACE_BITS-1:0] trace_ptr_reg; // Trace pointer
	logic [`EBL_CYC_BITS-1:0]   cyc_reg;       // Cycle counter
	logic                 probe_last_reg;   // Probe level last clock
	logic                 probe_seen_reg;   // Probe edge since last sample
	logic                 probe_smp_reg;    // Sampled at second cycle start

	// Decoded strobes
	logic                 wr_en;
	logic                 rd_setup;
	logic                 running;
	logic                 start_cmd;
	logic                 user_cmd;
	logic                 nexist_hit;
	logic                 ram_hit;
	logic                 tbl_d_hit;
	logic                 tbl_a_hit;
	logic [2:0]           hit_now;
	logic [24:0]          cyc_sum;
	logic [NC-1:0]        cause_set;
	logic [31:0]          rd_word;
	logic                 rd_ok;

	assign wr_en     = psel_i & penable_i & pwrite_i;
	assign rd_setup  = psel_i & ~penable_i & ~pwrite_i;
	assign running   = (run_reg != EBL_STOPPED);
	assign start_cmd = wr_en && paddr_i == `EBL_OFS_CTRL && pwdata_i[`EBL_CTRL_START];
	assign user_cmd  = wr_en && paddr_i == `EBL_OFS_CTRL && pwdata_i[`EBL_CTRL_USER];

	// Nonexistent code: beyond present size when not expanded, or test data area in any mode
	function automatic logic code_absent(input logic [15:0] a);
		logic in_test;
		in_test = (a >= `EBL_RST_TEST_BASE)
			&& ({1'b0, a} < {1'b0, `EBL_RST_TEST_BASE} + 17'(`EBL_TEST_WORDS));
		if (expand_reg)
			code_absent = in_test;
		else
			code_absent = in_test || ({1'b0, a} >= code_size_reg);
	endfunction

	// Match terms
	always_comb
	begin
		// Masked compare over all data addresses, special_function_location too
		ram_hit = core_ev_i.ram_wr
			&& ((core_ev_i.ram_addr & ram_mask_reg) == (ram_cmp_reg & ram_mask_reg));
		// Table data: exact address, masked data, optional qualifier
		tbl_d_hit = core_ev_i.tbl_rd && core_ev_i.tbl_addr == tbl_addr_reg
			&& ((core_ev_i.tbl_data & tbl_dmask_reg) == (tbl_data_reg & tbl_dmask_reg))
			&& (!tbl_iq_reg || core_ev_i.instr_addr == tbl_iaddr_reg);
		// Table address: masked address compare
		tbl_a_hit = core_ev_i.tbl_rd
			&& ((core_ev_i.tbl_addr & tbl_amask_reg) == (tbl_addr_reg & tbl_amask_reg));
		// Forced stop on absent fetch or table read
		nexist_hit = (core_ev_i.fetch && code_absent(core_ev_i.fetch_addr))
			|| (core_ev_i.tbl_rd && code_absent(core_ev_i.tbl_addr));
		// Kinds hit this clock, RAM on its final counted write
		hit_now[0] = enable_reg[`EBL_C_RAM_ADDR] && ram_hit
			&& (ram_hits_reg + 8'h01 == ram_count_reg);
		hit_now[1] = enable_reg[`EBL_C_TBL_DATA] && tbl_d_hit;
		hit_now[2] = enable_reg[`EBL_C_TBL_ADDR] && tbl_a_hit;
	end

	// Cycle counter sum with carry
	assign cyc_sum = {1'b0, cyc_reg} + {23'h000000, core_ev_i.instr_cycles};

	// New condition events, each gated by its enable except the forced breaks
	always_comb
	begin
		cause_set = '0;
		if (run_reg == EBL_RUNNING)
		begin
			// Delayed match kinds surface at the next instruction end
			if (core_ev_i.instr_done && match_late_reg)
			begin
				cause_set[`EBL_C_RAM_ADDR] = match_hold_reg[0];
				cause_set[`EBL_C_TBL_DATA] = match_hold_reg[1];
				cause_set[`EBL_C_TBL_ADDR] = match_hold_reg[2];
			end
			// Breakpoint only at executed first words
			cause_set[`EBL_C_BREAKPT] = enable_reg[`EBL_C_BREAKPT]
				&& core_ev_i.instr_done && bp_mem[core_ev_i.instr_addr];
			cause_set[`EBL_C_TRACE_FULL] = enable_reg[`EBL_C_TRACE_FULL]
				&& core_ev_i.trace_wr && (&trace_ptr_reg);
			cause_set[`EBL_C_CYC_OVF] = enable_reg[`EBL_C_CYC_OVF]
				&& core_ev_i.instr_done && cyc_sum[24];
			cause_set[`EBL_C_PROBE] = enable_reg[`EBL_C_PROBE]
				&& core_ev_i.s2_end && probe_smp_reg;
			cause_set[`EBL_C_HALT] = enable_reg[`EBL_C_HALT]
				&& core_ev_i.instr_done && core_ev_i.instr_halt;
			cause_set[`EBL_C_CALL_STK] = enable_reg[`EBL_C_CALL_STK]
				&& ((core_ev_i.call_push && core_ev_i.call_sp >= 5'(CALL_DEPTH))
				|| (core_ev_i.call_pop && core_ev_i.call_sp == 5'h00));
			cause_set[`EBL_C_REG_STK] = enable_reg[`EBL_C_REG_STK]
				&& ((core_ev_i.reg_push && core_ev_i.reg_sp >= 4'(REG_DEPTH))
				|| (core_ev_i.reg_pop && core_ev_i.reg_sp == 4'h0));
		end
		// Forced breaks ignore every enable
		if (running)
		begin
			cause_set[`EBL_C_NEXIST] = nexist_hit;
			cause_set[`EBL_C_USER]   = user_cmd;
		end
	end

	// Run state: start, request, acceptance, forced stop
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			run_reg <= EBL_STOPPED;
		else
		begin
			case (run_reg)
				EBL_STOPPED:
					if (start_cmd)
						run_reg <= EBL_RUNNING;
				EBL_RUNNING:
					if (cause_set[`EBL_C_NEXIST] || cause_set[`EBL_C_USER])
						run_reg <= EBL_STOPPED;
					else if (|cause_set)
						run_reg <= EBL_BREAKING;
				EBL_BREAKING:
					if (cause_set[`EBL_C_NEXIST] || cause_set[`EBL_C_USER])
						run_reg <= EBL_STOPPED;
					else if (break_ack_i)
						run_reg <= EBL_STOPPED;
				default:
					run_reg <= EBL_STOPPED;
			endcase
		end
	end

	// Sticky causes, cleared when a new run starts; clear wins over set
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			cause_reg <= '0;
		else if (start_cmd && !running)
			cause_reg <= '0;
		else
			cause_reg <= cause_reg | cause_set;
	end

	// RAM write counting and one-instruction delay of match kinds
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ram_hits_reg   <= 8'h00;
			match_now_reg  <= 1'b0;
			match_late_reg <= 1'b0;
			match_kind_reg <= 3'h0;
			match_hold_reg <= 3'h0;
		end
		else if (start_cmd && !running)
		begin
			// Fresh count and no stale matches at run start
			ram_hits_reg   <= 8'h00;
			match_now_reg  <= 1'b0;
			match_late_reg <= 1'b0;
			match_kind_reg <= 3'h0;
			match_hold_reg <= 3'h0;
		end
		else if (run_reg == EBL_RUNNING)
		begin
			// Count qualifying writes up to the programmed total
			if (enable_reg[`EBL_C_RAM_ADDR] && ram_hit && ram_hits_reg != ram_count_reg)
			begin
				ram_hits_reg <= ram_hits_reg + 8'h01;
				if (ram_hits_reg + 8'h01 == ram_count_reg)
				begin
					match_now_reg     <= 1'b1;
					match_kind_reg[0] <= 1'b1;
				end
			end
			// Table matches have no count: first hit counts
			if (enable_reg[`EBL_C_TBL_DATA] && tbl_d_hit)
			begin
				match_now_reg     <= 1'b1;
				match_kind_reg[1] <= 1'b1;
			end
			if (enable_reg[`EBL_C_TBL_ADDR] && tbl_a_hit)
			begin
				match_now_reg     <= 1'b1;
				match_kind_reg[2] <= 1'b1;
			end
			// Hand over at the instruction end, request one instruction later
			if (core_ev_i.instr_done)
			begin
				match_late_reg <= match_now_reg | (|hit_now);
				match_hold_reg <= match_kind_reg | hit_now;
				match_now_reg  <= 1'b0;
				match_kind_reg <= 3'h0;
			end
		end
	end

	// Trace pointer and cycle counter advance only while running
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			trace_ptr_reg <= '0;
			cyc_reg       <= '0;
		end
		else if (run_reg == EBL_RUNNING)
		begin
			// Pointer wraps over the 8192-entry table
			if (core_ev_i.trace_wr)
				trace_ptr_reg <= trace_ptr_reg + 13'h0001;
			// On carry the counter restarts at 1..cycles of that instruction
			if (core_ev_i.instr_done)
			begin
				if (cyc_sum[24])
					cyc_reg <= cyc_sum[23:0] + 24'h000001;
				else
					cyc_reg <= cyc_sum[23:0];
			end
		end
	end

	// Probe edge detect, sampled at second cycle start, taken at its end
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			probe_last_reg <= 1'b0;
			probe_seen_reg <= 1'b0;
			probe_smp_reg  <= 1'b0;
		end
		else
		begin
			probe_last_reg <= probe_stop_input_i;
			if (!running)
			begin
				probe_seen_reg <= 1'b0;
				probe_smp_reg  <= 1'b0;
			end
			else
			begin
				// Edge stays remembered until the next sample point
				if (probe_stop_input_i && !probe_last_reg)
					probe_seen_reg <= 1'b1;
				else if (core_ev_i.s2_start)
					probe_seen_reg <= 1'b0;
				if (core_ev_i.s2_start)
					probe_smp_reg <= probe_seen_reg || (probe_stop_input_i && !probe_last_reg);
				else if (core_ev_i.s2_end)
					probe_smp_reg <= 1'b0;
			end
		end
	end

	// Control and parameter registers
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			enable_reg    <= `EBL_RST_ENABLE;
			expand_reg    <= 1'b0;
			ram_cmp_reg   <= 12'h000;
			ram_mask_reg  <= 12'hfff;
			ram_count_reg <= 8'h01;
			tbl_addr_reg  <= 16'h0000;
			tbl_amask_reg <= 16'hffff;
			tbl_data_reg  <= 16'h0000;
			tbl_dmask_reg <= 16'hffff;
			tbl_iaddr_reg <= 16'h0000;
			tbl_iq_reg    <= 1'b0;
			bp_addr_reg   <= 16'h0000;
			code_size_reg <= `EBL_RST_CODE_SIZE;
		end
		else if (wr_en)
		begin
			case (paddr_i)
				`EBL_OFS_CTRL:      expand_reg <= pwdata_i[`EBL_CTRL_EXPAND];
				`EBL_OFS_ENABLE:    enable_reg <= pwdata_i[NE-1:0];
				`EBL_OFS_RAM_CMP:
				begin
					ram_cmp_reg  <= pwdata_i[11:0];
					ram_mask_reg <= pwdata_i[27:16];
				end
				`EBL_OFS_RAM_COUNT: ram_count_reg <= pwdata_i[7:0];
				`EBL_OFS_TBL_ADDR:
				begin
					tbl_addr_reg  <= pwdata_i[15:0];
					tbl_amask_reg <= pwdata_i[31:16];
				end
				`EBL_OFS_TBL_DATA:
				begin
					tbl_data_reg  <= pwdata_i[15:0];
					tbl_dmask_reg <= pwdata_i[31:16];
				end
				`EBL_OFS_TBL_IADDR:
				begin
					tbl_iaddr_reg <= pwdata_i[15:0];
					tbl_iq_reg    <= pwdata_i[16];
				end
				`EBL_OFS_BP_ADDR:   bp_addr_reg   <= pwdata_i[15:0];
				`EBL_OFS_CODE_SIZE: code_size_reg <= pwdata_i[16:0];
				default:            ;
			endcase
		end
	end

	// Breakpoint bit array, written one bit at the pointer
	always_ff @(posedge clk_i)
	begin
		if (wr_en && paddr_i == `EBL_OFS_BP_DATA)
			bp_mem[bp_addr_reg] <= pwdata_i[0];
	end

	// Read mux and address decode
	always_comb
	begin
		rd_word = 32'h00000000;
		rd_ok   = 1'b1;
		case (paddr_i)
			`EBL_OFS_CTRL:      rd_word = {29'h0, expand_reg, 1'b0, running};
			`EBL_OFS_ENABLE:    rd_word = {22'h0, enable_reg};
			`EBL_OFS_STATUS:    rd_word = {18'h0, run_reg, cause_reg};
			`EBL_OFS_RAM_CMP:   rd_word = {4'h0, ram_mask_reg, 4'h0, ram_cmp_reg};
			`EBL_OFS_RAM_COUNT: rd_word = {24'h0, ram_count_reg};
			`EBL_OFS_TBL_ADDR:  rd_word = {tbl_amask_reg, tbl_addr_reg};
			`EBL_OFS_TBL_DATA:  rd_word = {tbl_dmask_reg, tbl_data_reg};
			`EBL_OFS_TBL_IADDR: rd_word = {15'h0, tbl_iq_reg, tbl_iaddr_reg};
			`EBL_OFS_BP_ADDR:   rd_word = {16'h0, bp_addr_reg};
			`EBL_OFS_BP_DATA:   rd_word = {31'h0, bp_mem[bp_addr_reg]};
			`EBL_OFS_CODE_SIZE: rd_word = {15'h0, code_size_reg};
			`EBL_OFS_TRACE_PTR: rd_word = {19'h0, trace_ptr_reg};
			`EBL_OFS_CYCLES:    rd_word = {8'h0, cyc_reg};
			default:            rd_ok   = 1'b0;
		endcase
	end

	// Read data captured in the setup phase, held through the access
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			prdata_o <= 32'h00000000;
		else if (rd_setup)
			prdata_o <= rd_word;
	end

	// Zero-wait answer; unmapped offsets flag an error
	assign pready_o  = psel_i & penable_i;
	assign pslverr_o = psel_i & penable_i & ~rd_ok;

	// Core side outputs
	assign run_o        = running;
	assign break_req_o  = (run_reg == EBL_BREAKING);
	assign force_stop_o = running & (cause_set[`EBL_C_NEXIST] | cause_set[`EBL_C_USER]);
	assign halt_exit_o  = running & cause_set[`EBL_C_USER];

endmodule

// ---- dv/ebl_break_monitor.sv ----
`timescale 1ns/1ps
module ebl_break_monitor
	import ebl_pkg::*;
#(
	parameter int CALL_DEPTH = 16 // Call stack entries
)(
	input wire logic         clk_i,
	input wire logic         rst_i,
	input wire logic         psel_i,
	input wire logic         penable_i,
	input wire logic         pwrite_i,
	input wire logic [7:0]   paddr_i,
	input wire logic [31:0]  pwdata_i,
	input wire logic [31:0]  prdata_o,
	input wire logic         pready_o,
	input wire logic         pslverr_o,
	input wire ebl_core_ev_s core_ev_i,
	input wire logic         break_ack_i,
	input wire logic         probe_stop_input_i,
	input wire logic         run_o,
	input wire logic         break_req_o,
	input wire logic         force_stop_o,
	input wire logic         halt_exit_o
);
	logic [9:0] en_reg; // Copy of the enable register
	logic       live_w; // Running with no stop under way

	assign live_w = run_o && !break_req_o && !force_stop_o;

	// Track enable writes seen on the bus
	always_ff @(posedge clk_i or posedge rst_i)
		if (rst_i)
			en_reg <= 10'h000;
		else if (psel_i && penable_i && pwrite_i && paddr_i == 8'h04)
			en_reg <= pwdata_i[9:0];

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Core taking the request
	sequence s_accept;
		break_req_o && break_ack_i;
	endsequence

	a_accept_ends: assert property (s_accept |=> !run_o && !break_req_o)
		else $error("run kept going after acceptance");
	a_req_holds: assert property (break_req_o && !break_ack_i && !force_stop_o |=> break_req_o)
		else $error("break request dropped before acceptance");
	a_idle_quiet: assert property (!run_o |-> !break_req_o && !halt_exit_o)
		else $error("request while stopped");
	a_halt_req: assert property (live_w && en_reg[7] && core_ev_i.instr_done
		&& core_ev_i.instr_halt |=> break_req_o)
		else $error("halt gave no request");
	a_call_ovf: assert property (live_w && en_reg[8] && core_ev_i.call_push
		&& core_ev_i.call_sp >= 5'(CALL_DEPTH) |=> break_req_o)
		else $error("call stack overflow missed");
	a_reg_under: assert property (live_w && en_reg[9] && core_ev_i.reg_pop
		&& core_ev_i.reg_sp == 4'h0 |=> break_req_o)
		else $error("register stack underflow missed");
	a_test_area: assert property (run_o && !break_req_o && core_ev_i.fetch
		&& core_ev_i.fetch_addr[15:5] == 11'h07f |-> force_stop_o)
		else $error("test area fetch not stopped");
	a_forced_ends: assert property (force_stop_o |=> !run_o && !break_req_o)
		else $error("forced stop left run high");
	a_exit_user: assert property (halt_exit_o |-> force_stop_o && run_o)
		else $error("halt exit without forced stop");
endmodule

bind ebl_break_logic ebl_break_monitor #(.CALL_DEPTH(CALL_DEPTH)) ebl_break_monitor_inst (
	.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
	.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
	.pready_o(pready_o), .pslverr_o(pslverr_o), .core_ev_i(core_ev_i),
	.break_ack_i(break_ack_i), .probe_stop_input_i(probe_stop_input_i), .run_o(run_o),
	.break_req_o(break_req_o), .force_stop_o(force_stop_o), .halt_exit_o(halt_exit_o));

// ---- dv/ebl_core_model.sv ----
`timescale 1ns/1ps
module ebl_core_model
	import ebl_pkg::*;
(
	input  wire logic    clk_i,
	input  wire logic    rst_i,
	input  wire logic    break_req_i,
	output ebl_core_ev_s ev_o,
	output logic         ack_o,
	output logic         probe_o
);
	int ack_wait = 3; // Clocks before a request is accepted
	int wait_q;       // Clocks the request has waited

	initial
	begin
		ev_o    = '0;
		probe_o = 1'b0;
	end

	// Accept a pending request after the wait, one pulse
	always_ff @(posedge clk_i or posedge rst_i)
		if (rst_i)
		begin
			wait_q <= 0;
			ack_o  <= 1'b0;
		end
		else
		begin
			ack_o  <= break_req_i && !ack_o && wait_q >= ack_wait;
			wait_q <= (break_req_i && !ack_o) ? wait_q + 1 : 0;
		end

	// One event cycle; then idle, with table address, table data and RAM address inverted
	task automatic op(input int k, input logic [15:0] a, input logic [15:0] d);
		ebl_core_ev_s e; // Event sent
		ebl_core_ev_s q; // Idle value
		e = '0;
		e.instr_done   = (k <= 7);
		e.instr_addr   = a;
		e.instr_cycles = 2'h1;
		e.fetch_addr   = a;
		e.tbl_addr     = a;
		e.tbl_data     = d;
		e.ram_addr     = a[11:0];
		e.call_sp      = d[4:0];
		e.reg_sp       = d[3:0];
		case (k)
			1: e.instr_halt = 1'b1;
			2: e.ram_wr = 1'b1;
			3: e.tbl_rd = 1'b1;
			4: e.fetch = 1'b1;
			5: e.call_push = 1'b1;
			6: e.reg_push = 1'b1;
			7: e.reg_pop = 1'b1;
			8: e.s2_start = 1'b1;
			9: e.s2_end = 1'b1;
			10: e.trace_wr = 1'b1;
			default: ;
		endcase
		q = '0;
		q.tbl_addr = ~a;
		q.tbl_data = ~d;
		q.ram_addr = ~a[11:0];
		@(posedge clk_i);
		ev_o <= e;
		@(posedge clk_i);
		ev_o <= q;
	endtask

	// Probe level change
	task automatic set_probe(input logic v);
		@(posedge clk_i);
		probe_o <= v;
	endtask
endmodule

// ---- dv/tb.sv ----
`timescale 1ns/1ps
module tb
	import ebl_pkg::*;
;
	logic         clk;             // Clock
	logic         rst;             // Reset
	logic         psel;            // APB select
	logic         penable;         // APB enable
	logic         pwrite;          // APB direction
	logic [7:0]   paddr;           // APB address
	logic [31:0]  pwdata;          // APB write data
	logic [31:0]  prdata;          // APB read data
	logic         pready;          // APB ready
	logic         pslverr;         // APB error
	ebl_core_ev_s core_ev;         // Core events
	logic         ack;             // Acceptance
	logic         probe;           // Probe level
	logic         run;             // Running
	logic         brk;             // Break request
	logic         fstop;           // Forced stop
	logic         hexit;           // Halt exit
	logic [31:0]  rd;              // Last read word
	logic [2:0]   err;             // Halt exit, forced stop, error
	int           failures;        // Mismatches
	int           samples_checked; // Comparisons

	ebl_break_logic ebl_break_logic_inst (.clk_i(clk), .rst_i(rst), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .core_ev_i(core_ev),
		.break_ack_i(ack), .probe_stop_input_i(probe), .run_o(run), .break_req_o(brk),
		.force_stop_o(fstop), .halt_exit_o(hexit));
	ebl_core_model ebl_core_model_inst (.clk_i(clk), .rst_i(rst), .break_req_i(brk),
		.ev_o(core_ev), .ack_o(ack), .probe_o(probe));

	always #2.5 clk = ~clk;

	// Compare one word
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One APB transfer, held until ready
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = {hexit, fstop, pslverr};
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Program enables and start a run
	task automatic start(input logic [31:0] en, input logic [31:0] ctrl);
		apb(1'b1, 8'h04, en);
		apb(1'b1, 8'h00, ctrl);
		@(posedge clk);
		#1 chk("run", 32'h1, 32'(run));
	endtask

	// Send one event, then look at the request
	task automatic step(input int k, input logic [15:0] a, input logic [15:0] d,
		input logic exp);
		ebl_core_model_inst.op(k, a, d);
		#1 chk("break request", 32'(exp), 32'(brk));
	endtask

	// Wait for the stop, then check cause and state
	task automatic stopped(input int c);
		for (int n = 0; n < 20 && run !== 1'b0; n++)
			@(posedge clk);
		apb(1'b0, 8'h08, 32'h0);
		chk("stop cause", 32'h1, 32'({rd[13:12], rd[c]}));
	endtask

	// Verdict and end of run
	task automatic report_and_stop();
		$display("compared %0d mismatched %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Watchdog well beyond the expected run
	initial
	begin
		repeat (100000) @(posedge clk);
		failures++;
		report_and_stop();
	end

	// Main sequence
	initial
	begin
		clk = 1'b0; rst = 1'b1; psel = 1'b0; penable = 1'b0;
		pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
		failures = 0; samples_checked = 0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, 8'h04, 0); chk("enable reset", 32'h0, rd);
		apb(1'b0, 8'h10, 0); chk("count reset", 32'h1, rd);
		apb(1'b0, 8'h28, 0); chk("code size reset", 32'h2000, rd);
		apb(1'b0, 8'h40, 0); chk("unmapped error", 32'h1, 32'(err));
		chk("unmapped data", 32'h0, rd);
		start(32'h0, 32'h1); step(1, 16'h0100, 0, 1'b0);
		apb(1'b1, 8'h00, 32'h2); chk("user exit", 32'h6, 32'(err)); stopped(11);
		ebl_core_model_inst.ack_wait = 0;
		start(32'h80, 32'h1); step(1, 16'h0101, 0, 1'b1); stopped(7);
		apb(1'b1, 8'h0c, 32'h0ff0_0120); apb(1'b1, 8'h10, 32'h2);
		start(32'h1, 32'h1); step(2, 16'h0125, 0, 1'b0); step(2, 16'h0130, 0, 1'b0);
		step(2, 16'h012a, 0, 1'b0); step(0, 16'h0100, 0, 1'b1); stopped(0);
		apb(1'b1, 8'h14, 32'hffff_0300); apb(1'b1, 8'h18, 32'h0007_0004);
		apb(1'b1, 8'h1c, 32'h1_0555); start(32'h2, 32'h1);
		step(3, 16'h0300, 16'h000b, 1'b0); step(0, 16'h0100, 0, 1'b0);
		step(3, 16'h0300, 16'h000c, 1'b0); step(0, 16'h0100, 0, 1'b0);
		apb(1'b1, 8'h1c, 32'h1_0300);
		step(3, 16'h0300, 16'h000c, 1'b0); step(0, 16'h0100, 0, 1'b1); stopped(1);
		ebl_core_model_inst.ack_wait = 3;
		apb(1'b1, 8'h14, 32'hfff0_0800);
		start(32'h4, 32'h1); step(3, 16'h0810, 0, 1'b0); step(3, 16'h080f, 0, 1'b0);
		step(0, 16'h0100, 0, 1'b1); stopped(2);
		apb(1'b1, 8'h20, 32'h40); apb(1'b1, 8'h24, 32'h1);
		apb(1'b1, 8'h20, 32'h41); apb(1'b1, 8'h24, 32'h0);
		start(32'h8, 32'h1); step(0, 16'h0041, 0, 1'b0);
		step(0, 16'h0040, 0, 1'b1); stopped(3);
		start(32'h200, 32'h1); step(6, 0, 16'h7, 1'b0); step(7, 0, 16'h0, 1'b1); stopped(9);
		start(32'h100, 32'h1); step(5, 0, 16'hf, 1'b0); step(5, 0, 16'h10, 1'b1); stopped(8);
		start(32'h40, 32'h1); ebl_core_model_inst.set_probe(1'b1);
		step(8, 16'h0100, 0, 1'b0); step(9, 16'h0100, 0, 1'b1); stopped(6);
		ebl_core_model_inst.set_probe(1'b0);
		start(32'h10, 32'h1);
		for (int i = 0; i < 8191; i++)
			ebl_core_model_inst.op(10, 16'h0100, 0);
		#1 chk("trace early", 32'h0, 32'(brk));
		step(10, 16'h0100, 0, 1'b1); stopped(4);
		start(32'h0, 32'h1); step(4, 16'h1fff, 0, 1'b0);
		step(4, 16'h2000, 0, 1'b0); chk("absent stop", 32'h0, 32'(run)); stopped(10);
		start(32'h0, 32'h5); step(4, 16'h8000, 0, 1'b0); chk("expanded", 32'h1, 32'(run));
		step(4, 16'h0fff, 0, 1'b0); chk("test area", 32'h0, 32'(run)); stopped(10);
		report_and_stop();
	end
endmodule
